/* logic/pet_consts.svh */
`ifndef PET_CONSTS_SVH
`define PET_CONSTS_SVH

// ====================================================
// device register map
`define PET_ADDR_ENABLE 8'h80
`define PET_ADDR_RATE 8'h82
`define PET_ADDR_LOW_LSB 8'h88
`define PET_ADDR_LOW_MSB 8'h89
`define PET_ADDR_HIGH_LSB 8'h8a
`define PET_ADDR_HIGH_MSB 8'h8b
`define PET_ADDR_PERS 8'h8c
`define PET_ADDR_STATUS 8'h9b
`define PET_ADDR_RESULT_LSB 8'h9c
`define PET_ADDR_RESULT_MSB 8'h9d
`define PET_ADDR_WAIT_TIME 8'ha9
`define PET_ADDR_CONFIG_SIX_REG 8'hae

// ====================================================
// device fields and reset values
`define PET_BIT_POWER_ON 0
`define PET_BIT_DETECT_EN 2
`define PET_BIT_WAIT_EN 4
`define PET_ENABLE_MASK 8'h15
`define PET_BIT_APC_OFF 6
`define PET_BIT_ST_LOW 0
`define PET_BIT_ST_HIGH 1
`define PET_BIT_ST_INT 5
`define PET_RST_ENABLE 8'h00
`define PET_RST_RATE 8'h1f
`define PET_RST_THR 8'h00
`define PET_RST_CONFIG_SIX_REG 8'h3f
`define PET_RST_WAIT_TIME 8'h00

// ====================================================
// timing
`define PET_CLK_MHZ 10
`define PET_SAMPLE_UNIT_US 88
`define PET_SAMPLE_UNIT_CYC (`PET_SAMPLE_UNIT_US * `PET_CLK_MHZ)
`define PET_WAIT_UNIT_US 88
`define PET_WAIT_UNIT_CYC (`PET_WAIT_UNIT_US * `PET_CLK_MHZ)

// ====================================================
// controller register map (byte offsets)
`define PET_HOST_CMD 4'h0
`define PET_HOST_STATUS 4'h4
`define PET_HOST_IRQ_STATUS 4'h8
`define PET_HOST_IRQ_MASK 4'hc
`define PET_IRQ_DONE 0
`define PET_IRQ_DEVINT 1

`endif

/* logic/pet_pkg.sv */
package pet_pkg;

    // link transfer kinds
    typedef enum logic [1:0] {
        PET_LINK_SET_PTR = 2'b00,
        PET_LINK_WRITE = 2'b01,
        PET_LINK_READ = 2'b10
    } pet_link_kind_t;

    // measurement engine states
    typedef enum logic [1:0] {
        PET_ST_IDLE = 2'b00,
        PET_ST_SAMPLE = 2'b01,
        PET_ST_WAIT = 2'b10
    } pet_engine_state_t;

endpackage : pet_pkg

/* logic/pet_link.sv */
`timescale 1ns/10ps

// ====================================================
// byte-wide register link between controller and device
interface pet_link;
    import pet_pkg::*;
    logic req;
    pet_link_kind_t kind;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic intLevel;

    modport device (input req, input kind, input wdata, output ack, output rdata, output intLevel);
    modport host (output req, output kind, output wdata, input ack, input rdata, input intLevel);
endinterface : pet_link

/* logic/pet_breach.sv */
`timescale 1ns/10ps
`include "pet_consts.svh"

// ====================================================
// threshold compare and persistence filter
module pet_breach import pet_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic resultValid,
    input wire logic apcOff,
    input wire logic [13:0] result,
    input wire logic [13:0] lowThr,
    input wire logic [13:0] highThr,
    input wire logic [7:0] lowThr8,
    input wire logic [7:0] highThr8,
    input wire logic [3:0] persistence,
    output logic lowHit,
    output logic highHit
);
    logic [3:0] outCnt_q;
    logic [3:0] outCnt_d;
    logic lowHit_q;
    logic highHit_q;

    // 14-bit against full thresholds, 10-bit upper eight bits against byte thresholds
    wire [7:0] top8 = result[9:2];
    wire isBelow = apcOff ? (top8 < lowThr8) : (result < lowThr);
    wire isAbove = apcOff ? (top8 > highThr8) : (result > highThr);
    wire isOutside = isBelow | isAbove;
    // a setting of zero fires on every out-of-range result
    wire countReached = (persistence == 4'h0) || (outCnt_d == persistence);

    // RULE_17 count out-of-range runs
    assign outCnt_d = !isOutside ? 4'h0 : (outCnt_q == 4'hf ? 4'hf : outCnt_q + 4'h1);

    // counter and breach pulses
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outCnt_q <= 4'h0;
            lowHit_q <= 1'b0;
            highHit_q <= 1'b0;
        end else begin
            lowHit_q <= 1'b0;
            highHit_q <= 1'b0;
            if (resultValid) begin
                outCnt_q <= outCnt_d;
                // RULE_09 low breach check
                lowHit_q <= isBelow & countReached;
                // RULE_10 high breach check
                highHit_q <= isAbove & countReached;
            end
        end
    end

    assign lowHit = lowHit_q;
    assign highHit = highHit_q;
endmodule : pet_breach

/* logic/pet_device.sv */
// How it works
// RULE_01: power-on bit starts oscillator and converter
// RULE_02: detect enable bit runs measurement cycles
// RULE_03: wait enable inserts wait between cycles
// RULE_04: host writes reserved enable bits zero
// RULE_05: host configures everything before detect enable
// RULE_06: sample lasts (N+1) times 88 us
// RULE_07: low threshold is lsb plus msb[5:0]
// RULE_08: high threshold is lsb plus msb[5:0]
// RULE_09: low breach when below and persistence met
// RULE_10: high breach when above and persistence met
// RULE_11: host writes low lsb then msb
// RULE_12: host writes high lsb then msb
// RULE_13: lsb shadowed, both bytes latch on msb
// RULE_14: auto pulse control off gives 10-bit results
// RULE_15: 10-bit mode: low lsb vs top eight
// RULE_16: 10-bit mode: high lsb vs top eight
// RULE_17: count outside results, clear when inside
// RULE_18: auto-incrementing 8-bit pointer kept across transfers
// RULE_19: no cycle while power-on bit is zero
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`include "pet_consts.svh"

module pet_device import pet_pkg::*; #(
    parameter int SAMPLE_UNIT_CYC = `PET_SAMPLE_UNIT_CYC,
    parameter int WAIT_UNIT_CYC = `PET_WAIT_UNIT_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    pet_link.device link,
    input wire logic [13:0] rawSample,
    output logic oscOn,
    output logic detectRunning,
    output logic sampleDone,
    output logic [13:0] resultOut,
    output logic lowBreach,
    output logic highBreach
);
    // ====================================================
    // registers
    logic [7:0] pointer_q;
    logic [7:0] enable_q;
    logic [7:0] rate_q;
    logic [7:0] lowShadow_q;
    logic [7:0] lowLsb_q;
    logic [5:0] lowMsb_q;
    logic [7:0] highShadow_q;
    logic [7:0] highLsb_q;
    logic [5:0] highMsb_q;
    logic [3:0] pers_q;
    logic [7:0] config_six_reg_q;
    logic [7:0] waitTime_q;
    logic [13:0] result_q;
    logic [7:0] status_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic oscOn_q;
    logic running_q;
    logic sampleDone_q;
    pet_engine_state_t state_q;
    pet_engine_state_t state_d;
    logic [15:0] unitCnt_q;
    logic [7:0] stepCnt_q;
    logic [7:0] readMux;
    logic lowHit;
    logic highHit;

    // write strobe for one register address
    function automatic logic wrHit(input logic [7:0] ptr, input logic [7:0] addr, input logic wr);
        wrHit = wr && (ptr == addr);
    endfunction : wrHit

    // ====================================================
    // link decode
    wire isSetPtr = link.req && (link.kind == PET_LINK_SET_PTR);
    wire isWrite = link.req && (link.kind == PET_LINK_WRITE);
    wire isRead = link.req && (link.kind == PET_LINK_READ);
    wire wrEnable = wrHit(pointer_q, `PET_ADDR_ENABLE, isWrite);
    wire wrRate = wrHit(pointer_q, `PET_ADDR_RATE, isWrite);
    wire wrLowLsb = wrHit(pointer_q, `PET_ADDR_LOW_LSB, isWrite);
    wire wrLowMsb = wrHit(pointer_q, `PET_ADDR_LOW_MSB, isWrite);
    wire wrHighLsb = wrHit(pointer_q, `PET_ADDR_HIGH_LSB, isWrite);
    wire wrHighMsb = wrHit(pointer_q, `PET_ADDR_HIGH_MSB, isWrite);
    wire wrPers = wrHit(pointer_q, `PET_ADDR_PERS, isWrite);
    wire wrCfg6 = wrHit(pointer_q, `PET_ADDR_CONFIG_SIX_REG, isWrite);
    wire wrWaitTime = wrHit(pointer_q, `PET_ADDR_WAIT_TIME, isWrite);
    wire rdStatus = wrHit(pointer_q, `PET_ADDR_STATUS, isRead);

    // ====================================================
    // engine control
    wire powerOn = enable_q[`PET_BIT_POWER_ON];
    // RULE_19 detect gated by power
    wire runEngine = powerOn && enable_q[`PET_BIT_DETECT_EN];
    wire waitEnable = enable_q[`PET_BIT_WAIT_EN];
    wire apcOff = config_six_reg_q[`PET_BIT_APC_OFF];
    wire inWait = (state_q == PET_ST_WAIT);
    wire [15:0] unitLast = inWait ? 16'(WAIT_UNIT_CYC - 1) : 16'(SAMPLE_UNIT_CYC - 1);
    wire unitEnd = (unitCnt_q == unitLast);
    // RULE_06 (N+1) units per sample
    wire phaseEnd = unitEnd && (stepCnt_q == (inWait ? waitTime_q : rate_q));
    wire sampleEnd = (state_q == PET_ST_SAMPLE) && phaseEnd;
    // RULE_14 10-bit result when pulse control off
    wire [13:0] newResult = apcOff ? {4'h0, rawSample[13:4]} : rawSample;

    // next engine state
    always_comb begin
        state_d = state_q;
        case (state_q)
            PET_ST_IDLE: begin
                // RULE_02 start cycles
                if (runEngine) begin
                    state_d = PET_ST_SAMPLE;
                end
            end
            PET_ST_SAMPLE: begin
                // RULE_03 optional wait phase
                if (phaseEnd && waitEnable) begin
                    state_d = PET_ST_WAIT;
                end
            end
            PET_ST_WAIT: begin
                if (phaseEnd) begin
                    state_d = PET_ST_SAMPLE;
                end
            end
            default: begin
                state_d = PET_ST_IDLE;
            end
        endcase
        if (!runEngine) begin
            state_d = PET_ST_IDLE;
        end
    end

    // engine state and counters
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= PET_ST_IDLE;
            unitCnt_q <= 16'h0000;
            stepCnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            if (state_d != state_q || phaseEnd || state_q == PET_ST_IDLE) begin
                unitCnt_q <= 16'h0000;
                stepCnt_q <= 8'h00;
            end else if (unitEnd) begin
                unitCnt_q <= 16'h0000;
                stepCnt_q <= stepCnt_q + 8'h01;
            end else begin
                unitCnt_q <= unitCnt_q + 16'h0001;
            end
        end
    end

    // result capture and user outputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_q <= 14'h0000;
            sampleDone_q <= 1'b0;
            oscOn_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            sampleDone_q <= sampleEnd;
            if (sampleEnd) begin
                result_q <= newResult;
            end
            // RULE_01 oscillator follows power bit
            oscOn_q <= powerOn;
            running_q <= (state_d != PET_ST_IDLE);
        end
    end

    // ====================================================
    // threshold compare
    pet_breach breachUnit (
        .clock(clock),
        .rst_n(rst_n),
        .resultValid(sampleDone_q),
        .apcOff(apcOff),
        .result(result_q),
        // RULE_07 low 14-bit threshold
        .lowThr({lowMsb_q, lowLsb_q}),
        // RULE_08 high 14-bit threshold
        .highThr({highMsb_q, highLsb_q}),
        // RULE_15 low byte only
        .lowThr8(lowShadow_q),
        // RULE_16 high byte only
        .highThr8(highShadow_q),
        .persistence(pers_q),
        .lowHit(lowHit),
        .highHit(highHit)
    );

    // ====================================================
    // configuration registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_q <= `PET_RST_ENABLE;
            rate_q <= `PET_RST_RATE;
            lowShadow_q <= `PET_RST_THR;
            lowLsb_q <= `PET_RST_THR;
            lowMsb_q <= 6'h00;
            highShadow_q <= `PET_RST_THR;
            highLsb_q <= `PET_RST_THR;
            highMsb_q <= 6'h00;
            pers_q <= 4'h0;
            config_six_reg_q <= `PET_RST_CONFIG_SIX_REG;
            waitTime_q <= `PET_RST_WAIT_TIME;
        end else begin
            // RULE_04 reserved bits dropped
            if (wrEnable) enable_q <= link.wdata & `PET_ENABLE_MASK;
            if (wrRate) rate_q <= link.wdata;
            // RULE_13 shadow then latch both bytes
            if (wrLowLsb) lowShadow_q <= link.wdata;
            if (wrLowMsb) begin
                lowMsb_q <= link.wdata[5:0];
                lowLsb_q <= lowShadow_q;
            end
            if (wrHighLsb) highShadow_q <= link.wdata;
            if (wrHighMsb) begin
                highMsb_q <= link.wdata[5:0];
                highLsb_q <= highShadow_q;
            end
            if (wrPers) pers_q <= link.wdata[3:0];
            if (wrCfg6) config_six_reg_q <= link.wdata;
            if (wrWaitTime) waitTime_q <= link.wdata;
        end
    end

    // read selection
    always_comb begin
        case (pointer_q)
            `PET_ADDR_ENABLE: readMux = enable_q;
            `PET_ADDR_RATE: readMux = rate_q;
            `PET_ADDR_LOW_LSB: readMux = lowShadow_q;
            `PET_ADDR_LOW_MSB: readMux = {2'b00, lowMsb_q};
            `PET_ADDR_HIGH_LSB: readMux = highShadow_q;
            `PET_ADDR_HIGH_MSB: readMux = {2'b00, highMsb_q};
            `PET_ADDR_PERS: readMux = {4'h0, pers_q};
            `PET_ADDR_STATUS: readMux = status_q;
            `PET_ADDR_RESULT_LSB: readMux = result_q[7:0];
            `PET_ADDR_RESULT_MSB: readMux = {2'b00, result_q[13:8]};
            `PET_ADDR_WAIT_TIME: readMux = waitTime_q;
            `PET_ADDR_CONFIG_SIX_REG: readMux = config_six_reg_q;
            default: readMux = 8'h00;
        endcase
    end

    // ====================================================
    // pointer, answers and status
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pointer_q <= 8'h00;
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
            status_q <= 8'h00;
        end else begin
            ack_q <= link.req;
            // RULE_18 pointer set or auto-increment
            if (isSetPtr) begin
                pointer_q <= link.wdata;
            end else if (isWrite || isRead) begin
                pointer_q <= pointer_q + 8'h01;
            end
            if (isRead) rdata_q <= readMux;
            // status clears on read, new breach wins
            status_q[`PET_BIT_ST_LOW] <= lowHit | (status_q[`PET_BIT_ST_LOW] & ~rdStatus);
            status_q[`PET_BIT_ST_HIGH] <= highHit | (status_q[`PET_BIT_ST_HIGH] & ~rdStatus);
            // RULE_17 interrupt on count reached
            status_q[`PET_BIT_ST_INT] <= lowHit | highHit | (status_q[`PET_BIT_ST_INT] & ~rdStatus);
        end
    end

    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign link.intLevel = status_q[`PET_BIT_ST_INT];
    assign oscOn = oscOn_q;
    assign detectRunning = running_q;
    assign sampleDone = sampleDone_q;
    assign resultOut = result_q;
    assign lowBreach = lowHit;
    assign highBreach = highHit;
endmodule : pet_device

/* logic/pet_host.sv */
`timescale 1ns/10ps
`include "pet_consts.svh"

// ====================================================
// controller: Avalon-MM registers in, byte link out
module pet_host import pet_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    output logic irq,
    pet_link.host link
);
    logic waitreq_q;
    logic [31:0] readdata_q;
    logic req_q;
    pet_link_kind_t kind_q;
    logic [7:0] wdata_q;
    logic busy_q;
    logic [7:0] lastData_q;
    logic [1:0] irqStatus_q;
    logic [1:0] irqMask_q;
    logic devIntPrev_q;
    logic irq_q;
    logic [31:0] readMux;

    // byte-lane merge of a write
    function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
        beMerge = old;
    endfunction : beMerge

    // ====================================================
    // bus decode
    wire isCmd = (avsAddress == `PET_HOST_CMD);
    wire isIrqStatus = (avsAddress == `PET_HOST_IRQ_STATUS);
    wire isIrqMask = (avsAddress == `PET_HOST_IRQ_MASK);
    // RULE_11 order kept by software through serialised commands
    wire cmdStall = avsWrite && isCmd && busy_q;
    wire accept = (avsRead || avsWrite) && !waitreq_q;
    wire cmdAccept = accept && avsWrite && isCmd;
    wire [31:0] wrMerged = beMerge(32'h0000_0000, avsWritedata, avsByteenable);
    wire [1:0] clearBits = (accept && avsWrite && isIrqStatus) ? wrMerged[1:0] : 2'b00;
    wire devIntRise = link.intLevel && !devIntPrev_q;
    wire [1:0] events = {devIntRise, busy_q && link.ack};

    // read selection
    always_comb begin
        case (avsAddress)
            `PET_HOST_CMD: readMux = {22'h000000, kind_q, wdata_q};
            `PET_HOST_STATUS: readMux = {15'h0000, link.intLevel, lastData_q, 7'h00, busy_q};
            `PET_HOST_IRQ_STATUS: readMux = {30'h00000000, irqStatus_q};
            `PET_HOST_IRQ_MASK: readMux = {30'h00000000, irqMask_q};
            default: readMux = 32'h0000_0000;
        endcase
    end

    // bus handshake: one wait cycle, longer for a command write while a command is pending
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitreq_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else begin
            waitreq_q <= !((avsRead || avsWrite) && waitreq_q && !cmdStall);
            if (avsRead && waitreq_q) readdata_q <= readMux;
        end
    end

    // ====================================================
    // link command and interrupt registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_q <= 1'b0;
            kind_q <= PET_LINK_SET_PTR;
            wdata_q <= 8'h00;
            busy_q <= 1'b0;
            lastData_q <= 8'h00;
            irqStatus_q <= 2'b00;
            irqMask_q <= 2'b00;
            devIntPrev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            req_q <= cmdAccept;
            if (cmdAccept) begin
                kind_q <= pet_link_kind_t'(avsWritedata[9:8]);
                wdata_q <= avsWritedata[7:0];
                busy_q <= 1'b1;
            end else if (link.ack) begin
                busy_q <= 1'b0;
                lastData_q <= link.rdata;
            end
            if (accept && avsWrite && isIrqMask) begin
                irqMask_q <= wrMerged[1:0] | (irqMask_q & ~{2{avsByteenable[0]}});
            end
            // new event wins over clear
            irqStatus_q <= events | (irqStatus_q & ~clearBits);
            devIntPrev_q <= link.intLevel;
            irq_q <= |(irqStatus_q & irqMask_q);
        end
    end

    assign avsWaitrequest = waitreq_q;
    assign avsReaddata = readdata_q;
    assign irq = irq_q;
    assign link.req = req_q;
    assign link.kind = kind_q;
    assign link.wdata = wdata_q;
endmodule : pet_host

/* verification/pet_link_chk.sv */
`timescale 1ns/10ps

// ====================================================
// link and engine checker
module pet_link_chk import pet_pkg::*; (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic oscOn,
    input wire logic detectRunning,
    input wire logic sampleDone,
    input wire logic lowBreach,
    input wire logic highBreach
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_ACK_AFTER_REQ: assert property (req |=> ack)
        else $error("link request got no answer");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("link answer longer than one cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(req))
        else $error("link answer without request");
    AST_RDATA_HOLD: assert property (!ack |=> $stable(rdata) or ack)
        else $error("read byte moved outside an answer");
    AST_POWER_GATE: assert property (!oscOn [*2] |-> !detectRunning)
        else $error("engine running while unpowered");
    AST_SAMPLE_CAUSE: assert property (sampleDone |-> $past(detectRunning))
        else $error("sample finished while idle");
    AST_LOW_CAUSE: assert property (lowBreach |-> $past(sampleDone) && !highBreach)
        else $error("low breach without a finished sample");
    AST_HIGH_CAUSE: assert property (highBreach |-> $past(sampleDone))
        else $error("high breach without a finished sample");
endmodule : pet_link_chk

/* verification/tb_proximity_enable_threshold_regs.sv */
`timescale 1ns/10ps
`include "pet_consts.svh"

// ====================================================
// bench for the controller and device pair
module tb_proximity_enable_threshold_regs import pet_pkg::*;;
    logic clock, rst_n, avsRead, avsWrite, avsWaitrequest, irq;
    logic [3:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata, q;
    logic [13:0] rawSample, resultOut;
    logic oscOn, detectRunning, sampleDone, lowBreach, highBreach;
    int nFail, checked, lowCnt, highCnt, doneCnt, cyc, lastDone, period;
    logic [15:0] rstTab [7] = '{16'h8000, 16'h821f, 16'h8800, 16'h8900, 16'h8a00, 16'h8b00, 16'hae3f};

    pet_link lnk();
    pet_device #(.SAMPLE_UNIT_CYC(4), .WAIT_UNIT_CYC(4)) u_pet_device (.clock(clock), .rst_n(rst_n), .link(lnk),
        .rawSample(rawSample), .oscOn(oscOn), .detectRunning(detectRunning), .sampleDone(sampleDone),
        .resultOut(resultOut), .lowBreach(lowBreach), .highBreach(highBreach));
    pet_host u_pet_host (.clock(clock), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hf), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .irq(irq), .link(lnk));
    pet_link_chk u_pet_link_chk (.clock(clock), .rst_n(rst_n), .req(lnk.req), .ack(lnk.ack), .rdata(lnk.rdata),
        .oscOn(oscOn), .detectRunning(detectRunning), .sampleDone(sampleDone), .lowBreach(lowBreach),
        .highBreach(highBreach));

    // clock
    always #50 clock = ~clock;

    // pulse counters and sample spacing
    always @(posedge clock) begin
        cyc++;
        if (lowBreach === 1'b1) lowCnt++;
        if (highBreach === 1'b1) highCnt++;
        if (sampleDone === 1'b1) begin
            period = cyc - lastDone;
            lastDone = cyc;
            doneCnt++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one Avalon access, held until waitrequest is sampled low
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        do begin
            @(posedge clock);
        end while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : avs

    // one link transfer, polled until not busy
    task automatic link(input pet_link_kind_t k, input logic [7:0] d);
        avs(1'b1, `PET_HOST_CMD, {22'h0, k, d});
        do begin
            avs(1'b0, `PET_HOST_STATUS, 32'h0);
        end while (q[0] !== 1'b0);
    endtask : link

    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        link(PET_LINK_SET_PTR, a);
        link(PET_LINK_WRITE, d);
    endtask : dev_wr

    task automatic dev_rd(input logic [7:0] a);
        link(PET_LINK_SET_PTR, a);
        link(PET_LINK_READ, 8'h00);
    endtask : dev_rd

    // settle one sample, then count breaches over n samples
    task automatic measure(input logic [13:0] raw, input int n);
        int t;
        rawSample <= raw;
        for (int i = 0; i <= n; i++) begin
            t = doneCnt;
            while (doneCnt == t) @(posedge clock);
            if (i == 0) begin
                repeat (2) @(posedge clock);
                lowCnt = 0;
                highCnt = 0;
            end
        end
        repeat (2) @(posedge clock);
    endtask : measure

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, nFail);
        if (nFail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // watchdog
    initial begin
        #2000000;
        nFail++;
        print_verdict();
    end

    // ====================================================
    // tests
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 4'h0;
        avsWritedata = 32'h0;
        rawSample = 14'h0000;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rstTab[i]) begin
            dev_rd(rstTab[i][15:8]);
            check(q[15:8], rstTab[i][7:0]);
        end
        $display("test reset values done");
        dev_wr(8'h88, 8'h34);
        link(PET_LINK_WRITE, 8'h12);
        dev_wr(8'h8a, 8'h00);
        link(PET_LINK_WRITE, 8'h20);
        dev_rd(8'h89);
        check(q[15:8], 8'h12);
        dev_wr(8'h82, 8'h02);
        dev_wr(8'h80, 8'h04);
        repeat (40) @(posedge clock);
        check(doneCnt, 0);
        dev_wr(8'h80, 8'h01);
        check(oscOn, 1'b1);
        check(detectRunning, 1'b0);
        dev_wr(8'h80, 8'h05);
        $display("test setup done");
        measure(14'h0100, 3);
        check(detectRunning, 1'b1);
        check({lowCnt[15:0], highCnt[15:0]}, {16'd3, 16'd0});
        check(period, 12);
        measure(14'h1234, 2);
        check({lowCnt[15:0], highCnt[15:0]}, 32'h0);
        measure(14'h3000, 3);
        check({lowCnt[15:0], highCnt[15:0]}, {16'd0, 16'd3});
        dev_wr(8'h88, 8'h00);
        measure(14'h1233, 2);
        check(lowCnt, 2);
        dev_wr(8'h80, 8'h15);
        measure(14'h1800, 2);
        check(period, 16);
        dev_wr(8'h8c, 8'h03);
        measure(14'h0100, 6);
        check(lowCnt, 1);
        $display("test 14-bit compare done");
        dev_wr(8'h80, 8'h01);
        dev_wr(8'h8c, 8'h00);
        dev_wr(8'hae, 8'h7f);
        dev_wr(8'h88, 8'h40);
        dev_wr(8'h8a, 8'h80);
        dev_wr(8'h80, 8'h05);
        measure(14'h0f00, 2);
        check(resultOut, 14'h00f0);
        check({lowCnt[15:0], highCnt[15:0]}, {16'd2, 16'd0});
        measure(14'h2400, 2);
        check({lowCnt[15:0], highCnt[15:0]}, {16'd0, 16'd2});
        $display("test 10-bit compare done");
        avs(1'b1, `PET_HOST_IRQ_MASK, 32'h0);
        link(PET_LINK_SET_PTR, 8'h80);
        avs(1'b0, `PET_HOST_IRQ_STATUS, 32'h0);
        check({irq, q[0]}, 2'b01);
        avs(1'b1, `PET_HOST_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clock);
        check(irq, 1'b1);
        avs(1'b1, `PET_HOST_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clock);
        check(irq, 1'b0);
        avs(1'b0, 4'h2, 32'h0);
        check(q, 32'h0);
        avs(1'b0, `PET_HOST_STATUS, 32'h0);
        check(q[16], 1'b1);
        $display("test host registers done");
        print_verdict();
    end
endmodule : tb_proximity_enable_threshold_regs
